// ===== src/tac_regs.svh
/*
 Register offsets, field positions and reset values of the TDC auxiliary control.
 Assumes a 4-bit host address and 8-bit host data.
*/
`ifndef TAC_REGS_SVH
`define TAC_REGS_SVH
// Host register addresses
`define TAC_ADDR_CTRL0      4'h0
`define TAC_ADDR_CLKDIV_A   4'h4
`define TAC_ADDR_CLKDIV_B   4'h5
`define TAC_ADDR_CTRL6      4'h6
`define TAC_ADDR_STATUS     4'h8
// Field positions
`define TAC_CTRL0_CAL_BIT   4
`define TAC_CTRL0_MUL_BIT   5
`define TAC_CTRL6_INT_BIT   7
`define TAC_STAT_CAL_BIT    0
`define TAC_STAT_MUL_BIT    1
`define TAC_DIVA_CAL_LSB    0
`define TAC_DIVA_LOOP_LSB   3
`define TAC_DIVB_RC_LSB     0
// Reset values
`define TAC_CTRL0_RST       8'h00
`define TAC_CLKDIV_A_RST    8'h00
`define TAC_CLKDIV_B_RST    8'h00
`define TAC_CTRL6_RST       8'h00
`endif

// ===== src/tac_pkg.sv
/*
 Types shared by the TDC auxiliary control.
 Assumes the register header is included alongside.
*/
package tac_pkg;
    typedef logic [2:0] tac_div_sel_t;
    typedef logic [7:0] tac_byte_t;
    typedef logic [3:0] tac_addr_t;
    typedef enum logic [0:0] {
        TAC_INT_RESULT   = 1'b0,
        TAC_INT_OVERFLOW = 1'b1
    } tac_int_src_t;
endpackage

// ===== src/tac_aux_control.sv
/*
 Auxiliary control of a time-to-digital converter: stop gating, interrupt flag,
 three reference clock dividers and the 8-bit host register port.
 Assumes all inputs synchronous to ref_clk_in; host strobes last several cycles.
*/
// Notes on behaviour
// - Each stop channel has its own gate; high admits, low blocks.
// - Stop gates never affect the start input.
// - Gates are sampled every clock, so single stops can be masked.
// - Interrupt source is result-register write (default) or unit overflow.
// - Interrupt source select lives in control register 6 bit 7.
// - Interrupt flag rises when the selected event occurs.
// - Three divided clocks: calibration, loop reference, RC unit control.
// - Codes 0..7 divide by 1,2,4,8,16,32,64,64; RC code 6 divides by 32.
// - Divider selects sit in host-writable registers 4 and 5.
// - Status mirrors calibrate and multiply bits of control register 0.
// - Address latch is transparent while enable is high, holds after.
`timescale 1ns/1ps
`default_nettype none
`include "tac_regs.svh"

module tac_aux_control
(
    input  wire logic                ref_clk_in,
    input  wire logic                srst_in,
    input  wire logic                start_in,
    input  wire logic                stop1_in,
    input  wire logic                stop2_in,
    input  wire logic                stop1_gate_in,
    input  wire logic                stop2_gate_in,
    input  wire logic                result_write_in,
    input  wire logic                overflow_in,
    input  wire tac_pkg::tac_addr_t  addr_in,
    input  wire logic                ale_in,
    input  wire logic                cs_n_in,
    input  wire logic                read_strobe_n_in,
    input  wire logic                write_strobe_n_in,
    input  wire tac_pkg::tac_byte_t  data_in,
    output tac_pkg::tac_byte_t       data_out,
    output logic                     data_oe_n_out,
    output logic                     start_event_out,
    output logic                     stop1_event_out,
    output logic                     stop2_event_out,
    output logic                     int_flag_out,
    output logic                     cal_tick_out,
    output logic                     loop_tick_out,
    output logic                     rc_tick_out,
    output logic                     calibrate_out,
    output logic                     multiply_out
);
    import tac_pkg::*;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    // Division factor as a mask of low counter bits; used by all three dividers
    function automatic logic [5:0] div_mask(input tac_div_sel_t sel, input logic rc);
        logic [2:0] sh;
        sh = (sel == 3'h7) ? 3'h6 : sel;
        if (rc && sel == 3'h6)
        begin
            sh = 3'h5;
        end
        div_mask = 6'((7'h01 << sh) - 7'h01);
    endfunction

    // ------------------------------------------------------------ host port
    tac_addr_t addr_latch_reg, addr_latch_next;
    tac_addr_t addr_eff;
    logic      wr_n_reg, wr_n_next;
    tac_byte_t wdata_reg, wdata_next;
    tac_byte_t ctrl0_reg, ctrl0_next;
    tac_byte_t diva_reg, diva_next;
    tac_byte_t divb_reg, divb_next;
    tac_byte_t ctrl6_reg, ctrl6_next;
    tac_byte_t rdata_reg, rdata_next;
    logic      wr_commit;
    logic      rd_active;
    logic      rd_n_reg, rd_n_next;

    // Address path
    // transparent address latch
    assign addr_eff  = ale_in ? addr_in : addr_latch_reg;
    // Write lands on the rising strobe edge, as the host expects
    assign wr_commit = !wr_n_reg && write_strobe_n_in;
    assign rd_active = !cs_n_in && !read_strobe_n_in;

    // Next state of host registers
    always_comb
    begin
        addr_latch_next = addr_eff;
        wr_n_next       = write_strobe_n_in | cs_n_in;
        wdata_next      = (!write_strobe_n_in && !cs_n_in) ? data_in : wdata_reg;
        rd_n_next       = !rd_active;
        ctrl0_next      = ctrl0_reg;
        diva_next       = diva_reg;
        divb_next       = divb_reg;
        ctrl6_next      = ctrl6_reg;
        if (wr_commit)
        begin
            unique case (addr_eff)
                `TAC_ADDR_CTRL0:    ctrl0_next = wdata_reg;
                `TAC_ADDR_CLKDIV_A: diva_next  = wdata_reg;
                `TAC_ADDR_CLKDIV_B: divb_next  = wdata_reg;
                `TAC_ADDR_CTRL6:    ctrl6_next = wdata_reg;
                default:            ctrl0_next = ctrl0_reg;
            endcase
        end
        rdata_next = 8'h00;
        unique case (addr_eff)
            `TAC_ADDR_CTRL0:    rdata_next = ctrl0_reg;
            `TAC_ADDR_CLKDIV_A: rdata_next = diva_reg;
            `TAC_ADDR_CLKDIV_B: rdata_next = divb_reg;
            `TAC_ADDR_CTRL6:    rdata_next = ctrl6_reg;
            `TAC_ADDR_STATUS:
            begin
                rdata_next[`TAC_STAT_CAL_BIT] = ctrl0_reg[`TAC_CTRL0_CAL_BIT];
                rdata_next[`TAC_STAT_MUL_BIT] = ctrl0_reg[`TAC_CTRL0_MUL_BIT];
            end
            default:            rdata_next = 8'h00;
        endcase
    end

    // Host registers
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            addr_latch_reg <= 4'h0;
            wr_n_reg       <= 1'b1;
            rd_n_reg       <= 1'b1;
            wdata_reg      <= 8'h00;
            ctrl0_reg      <= `TAC_CTRL0_RST;
            diva_reg       <= `TAC_CLKDIV_A_RST;
            divb_reg       <= `TAC_CLKDIV_B_RST;
            ctrl6_reg      <= `TAC_CTRL6_RST;
            rdata_reg      <= 8'h00;
        end
        else
        begin
            addr_latch_reg <= addr_latch_next;
            wr_n_reg       <= wr_n_next;
            rd_n_reg       <= rd_n_next;
            wdata_reg      <= wdata_next;
            ctrl0_reg      <= ctrl0_next;
            diva_reg       <= diva_next;
            divb_reg       <= divb_next;
            ctrl6_reg      <= ctrl6_next;
            rdata_reg      <= rdata_next;
        end
    end

    // Bus drive; data trails the address by one clock
    // drive only during reads
    assign data_oe_n_out = !rd_active;
    assign data_out      = rdata_reg;
    assign calibrate_out = ctrl0_reg[`TAC_CTRL0_CAL_BIT];
    assign multiply_out  = ctrl0_reg[`TAC_CTRL0_MUL_BIT];

    // ---------------------------------------------------- gating and flag
    logic         start_ev_reg, start_ev_next;
    logic         stop1_ev_reg, stop1_ev_next;
    logic         stop2_ev_reg, stop2_ev_next;
    logic         int_reg, int_next;
    logic         int_event;
    logic         rd_begin;
    tac_int_src_t int_src;

    assign int_src  = tac_int_src_t'(ctrl6_reg[`TAC_CTRL6_INT_BIT]);
    assign int_event = (int_src == TAC_INT_RESULT) ? result_write_in : overflow_in;
    // Flag drops at the start of the next host read; a new event wins
    assign rd_begin = rd_active && rd_n_reg;

    always_comb
    begin
        stop1_ev_next = stop1_in & stop1_gate_in;
        stop2_ev_next = stop2_in & stop2_gate_in;
        start_ev_next = start_in;
        int_next = int_event | (int_reg & !rd_begin);
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            start_ev_reg <= 1'b0;
            stop1_ev_reg <= 1'b0;
            stop2_ev_reg <= 1'b0;
            int_reg      <= 1'b0;
        end
        else
        begin
            start_ev_reg <= start_ev_next;
            stop1_ev_reg <= stop1_ev_next;
            stop2_ev_reg <= stop2_ev_next;
            int_reg      <= int_next;
        end
    end

    assign start_event_out = start_ev_reg;
    assign stop1_event_out = stop1_ev_reg;
    assign stop2_event_out = stop2_ev_reg;
    assign int_flag_out    = int_reg;

    // ------------------------------------------------------------ dividers
    // One shared free counter keeps the three clocks phase related
    logic [5:0]   div_cnt_reg, div_cnt_next;
    tac_div_sel_t sel_cal, sel_loop, sel_rc;
    logic [5:0]   mask_cal, mask_loop, mask_rc;

    assign sel_cal  = diva_reg[`TAC_DIVA_CAL_LSB +: 3];
    assign sel_loop = diva_reg[`TAC_DIVA_LOOP_LSB +: 3];
    assign sel_rc   = divb_reg[`TAC_DIVB_RC_LSB +: 3];

    always_comb
    begin
        div_cnt_next = div_cnt_reg + 6'h01;
        mask_cal  = div_mask(sel_cal, 1'b0);
        mask_loop = div_mask(sel_loop, 1'b0);
        mask_rc   = div_mask(sel_rc, 1'b1);
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            div_cnt_reg <= 6'h00;
        end
        else
        begin
            div_cnt_reg <= div_cnt_next;
        end
    end

    assign cal_tick_out  = (div_cnt_reg & mask_cal) == mask_cal;
    assign loop_tick_out = (div_cnt_reg & mask_loop) == mask_loop;
    assign rc_tick_out   = (div_cnt_reg & mask_rc) == mask_rc;

    // ---------------------------------------------------------- assertions
    sequence s_wr_div_a;
        wr_commit && addr_eff == `TAC_ADDR_CLKDIV_A;
    endsequence

    sequence s_status_read;
        rd_active && addr_eff == `TAC_ADDR_STATUS;
    endsequence

    property p_stop1_gate;
        !stop1_gate_in |=> !stop1_event_out;
    endproperty
    a_stop1_gate: assert property (p_stop1_gate) else $error("stop1 passed while gated");

    property p_stop2_pass;
        (stop2_in && stop2_gate_in) |=> stop2_event_out;
    endproperty
    a_stop2_pass: assert property (p_stop2_pass) else $error("stop2 lost while open");

    property p_start_free;
        (start_in && !stop1_gate_in && !stop2_gate_in) |=> start_event_out;
    endproperty
    a_start_free: assert property (p_start_free) else $error("start blocked by gates");

    property p_int_result;
        (result_write_in && !ctrl6_reg[`TAC_CTRL6_INT_BIT]) |=> int_flag_out;
    endproperty
    a_int_result: assert property (p_int_result) else $error("flag missed result write");

    property p_int_overflow_only;
        (!int_flag_out && ctrl6_reg[`TAC_CTRL6_INT_BIT] && !overflow_in)
            |=> !int_flag_out;
    endproperty
    a_int_overflow_only: assert property (p_int_overflow_only) else $error("flag from wrong source");

    property p_int_rise;
        $rose(int_flag_out) |-> $past(int_event);
    endproperty
    a_int_rise: assert property (p_int_rise) else $error("flag rose without event");

    property p_div_write;
        s_wr_div_a |=> sel_cal == $past(wdata_reg[2:0]);
    endproperty
    a_div_write: assert property (p_div_write) else $error("divider select not stored");

    property p_cal_div64;
        (cal_tick_out && sel_cal == 3'h7 && !wr_commit) |=> !cal_tick_out [*8];
    endproperty
    a_cal_div64: assert property (p_cal_div64) else $error("cal divider too fast");

    property p_rc_div32;
        (rc_tick_out && sel_rc == 3'h6) |=> !rc_tick_out [*8]
            ##24 (rc_tick_out || sel_rc != 3'h6);
    endproperty
    a_rc_div32: assert property (p_rc_div32) else $error("rc code 6 not by 32");

    property p_loop_div1;
        (sel_loop == 3'h0) |-> loop_tick_out;
    endproperty
    a_loop_div1: assert property (p_loop_div1) else $error("loop clock not undivided");

    property p_status_mirror;
        s_status_read |=> data_out[`TAC_STAT_CAL_BIT] == calibrate_out
            && data_out[`TAC_STAT_MUL_BIT] == multiply_out;
    endproperty
    a_status_mirror: assert property (p_status_mirror) else $error("status does not mirror");

    property p_ale_pass;
        ale_in |=> addr_latch_reg == $past(addr_in);
    endproperty
    a_ale_pass: assert property (p_ale_pass) else $error("latch not transparent");

    property p_bus_release;
        (cs_n_in || read_strobe_n_in) |-> data_oe_n_out;
    endproperty
    a_bus_release: assert property (p_bus_release) else $error("bus driven outside read");

endmodule

`default_nettype wire

// ===== bench/tac_host_model.sv
/*
 Behavioural host controller for the TDC auxiliary control register port.
 Assumes a resolved data bus and the shared reference clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tac_host_model
(
    input  wire logic               clk_in,
    input  wire tac_pkg::tac_byte_t bus_in,
    input  wire logic               oe_n_in,
    output tac_pkg::tac_addr_t      addr_out,
    output logic                    ale_out,
    output logic                    cs_n_out,
    output logic                    rd_n_out,
    output logic                    wr_n_out,
    output tac_pkg::tac_byte_t      data_out
);
    import tac_pkg::*;

    // Idle: deselected, latch held open
    // ale held high
    initial
    begin
        addr_out = 4'hF;
        ale_out  = 1'b1;
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        data_out = 8'hA5;
    end

    // Strobe levels change together just after an edge
    task automatic ctl(input logic cs_n, input logic rd_n, input logic wr_n);
    begin
        cs_n_out <= cs_n;
        rd_n_out <= rd_n;
        wr_n_out <= wr_n;
    end
    endtask

    // Write: strobe low two clocks, address held past the commit edge
    // host side of loopback
    task automatic write_reg(input tac_addr_t a, input tac_byte_t v);
    begin
        @(posedge clk_in);
        addr_out <= a;
        data_out <= v;
        ctl(1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge clk_in);
        ctl(1'b1, 1'b1, 1'b1);
        @(posedge clk_in);
        data_out <= ~v; // Released data never shows the last value
    end
    endtask

    // Open the latch on one address, then close it
    task automatic latch_addr(input tac_addr_t a);
    begin
        @(posedge clk_in);
        addr_out <= a;
        ale_out  <= 1'b1;
        @(posedge clk_in);
        ale_out  <= 1'b0;
    end
    endtask

    // Read: data taken at the edge that ends a two-clock strobe
    task automatic read_reg(input tac_addr_t a, input logic use_ale,
                            output tac_byte_t v, output logic oe_n);
    begin
        @(posedge clk_in);
        addr_out <= use_ale ? a : ~a;
        ale_out  <= use_ale;
        ctl(1'b0, 1'b0, 1'b1);
        repeat (2) @(posedge clk_in);
        v = bus_in;
        oe_n = oe_n_in;
        ctl(1'b1, 1'b1, 1'b1);
        ale_out <= 1'b1;
    end
    endtask
endmodule

`default_nettype wire

// ===== bench/tac_aux_control_tb.sv
/*
 Self-checking bench of the TDC auxiliary control.
 Assumes the host model drives the register port; bench drives events.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tac_regs.svh"

module tac_aux_control_tb;
    import tac_pkg::*;

    logic      ref_clk_in = 1'b0;
    logic      srst_in = 1'b1;
    logic      start_in = 1'b0;
    logic      stop1_in = 1'b0;
    logic      stop2_in = 1'b0;
    logic      stop1_gate_in = 1'b1;
    logic      stop2_gate_in = 1'b1;
    logic      result_write_in = 1'b0;
    logic      overflow_in = 1'b0;
    tac_addr_t addr;
    tac_byte_t host_data, dev_data, bus, rv;
    logic      ale, cs_n, rd_n, wr_n, oe_n, roe, cal, mul;
    logic      st_ev, s1_ev, s2_ev, int_flag, cal_tk, loop_tk, rc_tk;
    logic [7:0] nc, nl, nr;
    int        fails = 0;
    int        comparisons = 0;

    // 10 MHz reference clock
    always #50 ref_clk_in = ~ref_clk_in;
    // Wire level: device drives only while its enable is low
    assign bus = oe_n ? host_data : dev_data;

    tac_aux_control DUT (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .start_in(start_in),
        .stop1_in(stop1_in), .stop2_in(stop2_in), .stop1_gate_in(stop1_gate_in),
        .stop2_gate_in(stop2_gate_in), .result_write_in(result_write_in),
        .overflow_in(overflow_in), .addr_in(addr), .ale_in(ale), .cs_n_in(cs_n),
        .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n), .data_in(bus),
        .data_out(dev_data), .data_oe_n_out(oe_n), .start_event_out(st_ev),
        .stop1_event_out(s1_ev), .stop2_event_out(s2_ev), .int_flag_out(int_flag),
        .cal_tick_out(cal_tk), .loop_tick_out(loop_tk), .rc_tick_out(rc_tk),
        .calibrate_out(cal), .multiply_out(mul));

    tac_host_model HOST (.clk_in(ref_clk_in), .bus_in(bus), .oe_n_in(oe_n),
        .addr_out(addr), .ale_out(ale), .cs_n_out(cs_n), .rd_n_out(rd_n),
        .wr_n_out(wr_n), .data_out(host_data));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    begin
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask

    // Read through the host and compare; bus must be driven then released
    task automatic rd_check(input string name, input tac_addr_t a, input tac_byte_t exp);
    begin
        HOST.read_reg(a, 1'b1, rv, roe);
        check(name, rv, exp);
        check("drive enable", {7'h00, roe}, 8'h00);
        @(negedge ref_clk_in);
        check("bus released", {7'h00, oe_n}, 8'h01);
    end
    endtask

    // One-cycle event pulse; flag looked at once the registered answer has landed
    task automatic pulse(input logic ovf, input logic exp);
    begin
        @(posedge ref_clk_in);
        overflow_in <= ovf;
        result_write_in <= ~ovf;
        @(posedge ref_clk_in);
        overflow_in <= 1'b0;
        result_write_in <= 1'b0;
        repeat (2) @(negedge ref_clk_in);
        check("int flag", {7'h00, int_flag}, {7'h00, exp});
    end
    endtask

    // 128 cycles hold a whole number of periods of every factor
    task automatic count_ticks();
    begin
        nc = 8'h00;
        nl = 8'h00;
        nr = 8'h00;
        repeat (128)
        begin
            @(negedge ref_clk_in);
            nc = nc + {7'h00, cal_tk};
            nl = nl + {7'h00, loop_tk};
            nr = nr + {7'h00, rc_tk};
        end
    end
    endtask

    function automatic logic [7:0] ticks(input logic [2:0] c, input logic rc);
        return 8'h80 >> ((c == 3'h7) ? 6 : (rc && c == 3'h6) ? 5 : int'(c));
    endfunction

    task automatic print_verdict;
    begin
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask

    initial
    begin
        repeat (10) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        rd_check("ctrl0", `TAC_ADDR_CTRL0, `TAC_CTRL0_RST);
        rd_check("div a", `TAC_ADDR_CLKDIV_A, `TAC_CLKDIV_A_RST);
        rd_check("div b", `TAC_ADDR_CLKDIV_B, `TAC_CLKDIV_B_RST);
        rd_check("ctrl6", `TAC_ADDR_CTRL6, `TAC_CTRL6_RST);
        rd_check("unmapped", 4'h3, 8'h00);
        // Loopback of calibrate and multiply bits, each alone and together
        for (int i = 1; i < 4; i++)
        begin
            HOST.write_reg(`TAC_ADDR_CTRL0, 8'(i << 4));
            rd_check("status", `TAC_ADDR_STATUS, 8'(i));
            check("cal mul", {6'h00, mul, cal}, 8'(i));
        end
        // Every divider code on all three clocks
        for (int c = 0; c < 8; c++)
        begin
            HOST.write_reg(`TAC_ADDR_CLKDIV_A, {2'b00, c[2:0], c[2:0]});
            HOST.write_reg(`TAC_ADDR_CLKDIV_B, {5'h00, c[2:0]});
            rd_check("div a", `TAC_ADDR_CLKDIV_A, {2'b00, c[2:0], c[2:0]});
            count_ticks();
            check("cal ticks", nc, ticks(c[2:0], 1'b0));
            check("loop ticks", nl, ticks(c[2:0], 1'b0));
            check("rc ticks", nr, ticks(c[2:0], 1'b1));
        end
        // Gates flip while stops stay high; start follows its own pattern
        for (int g = 0; g < 4; g++)
        begin
            @(posedge ref_clk_in);
            stop1_gate_in <= g[0];
            stop2_gate_in <= g[1];
            start_in <= g[0] ~^ g[1];
            stop1_in <= 1'b1;
            stop2_in <= 1'b1;
            repeat (2) @(negedge ref_clk_in);
            check("stop1 event", {7'h00, s1_ev}, {7'h00, g[0]});
            check("stop2 event", {7'h00, s2_ev}, {7'h00, g[1]});
            check("start event", {7'h00, st_ev}, {7'h00, g[0] ~^ g[1]});
        end
        @(posedge ref_clk_in);
        {stop1_gate_in, stop2_gate_in, start_in, stop1_in, stop2_in} <= 5'b11000;
        // Default source, then overflow source; reads clear the flag
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b1);
        rd_check("status", `TAC_ADDR_STATUS, 8'h03);
        check("int cleared", {7'h00, int_flag}, 8'h00);
        HOST.write_reg(`TAC_ADDR_CTRL6, 8'h80);
        pulse(1'b0, 1'b0);
        pulse(1'b1, 1'b1);
        // Latched address survives a changed address bus
        HOST.latch_addr(`TAC_ADDR_CTRL6);
        HOST.read_reg(`TAC_ADDR_CTRL6, 1'b0, rv, roe);
        check("latched read", rv, 8'h80);
        print_verdict();
    end
endmodule

`default_nettype wire
